// File: hdl/i2cms_pkg.sv
// Purpose: constants and types for the serial-bus register map selector
// Assumes: byte-level events come from a separate serial-bus bit engine
// Notes: bus ids are full address bytes, bit 0 carries the direction
//
// Summary of operation
// - answer main map at 0x40/0x41 with select pin low, 0x42/0x43 high, except while page is 11.
// - three sub maps share main id; page field at 0x0E bits 6:5 picks.
// - page 00 routes main-map accesses to the user sub map.
// - page 01 routes main-map accesses to the interrupt and vbi decode sub map.
// - page 10 routes main-map accesses to the second user sub map.
// - with no page write, main-map accesses reach the user sub map.
// - deinterlacer map id is 0xFD bits 7:1; writes on id, reads id plus one.
// - deinterlacer id resets to 0x00; map unreachable until bits 7:1 are programmed nonzero.
// - serial-output map id is 0xFE bits 7:1; writes on id, reads plus one.
// - serial-output id resets to 0x00; map unreachable until bits 7:1 are programmed nonzero.
// - deinterlacer and serial-output decode ignore select pin and page field.
// - select pin drives address bit 1; bit 0 is one for read, zero for write.
// - a location outside the selected map is not acknowledged; go idle.
package i2cms_pkg;

  // ----------------------------------------------------------------
  // addresses and locations
  // ----------------------------------------------------------------
  localparam logic [5:0] MAIN_ID_HIGH = 6'h10;
  localparam logic [7:0] PAGE_LOC = 8'h0E;
  localparam int PAGE_LSB = 5;
  localparam logic [7:0] DEINT_LOC = 8'hFD;
  localparam logic [7:0] SEROUT_LOC = 8'hFE;
  localparam logic [7:0] LOC_TOP_DEFAULT = 8'hFF;

  // ----------------------------------------------------------------
  // reset values and page codes
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] MAP_ID_RST = 8'h00;
  localparam logic [1:0] PAGE_USER = 2'h0;
  localparam logic [1:0] PAGE_INTVBI = 2'h1;
  localparam logic [1:0] PAGE_USER2 = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {MAP_NONE, MAP_USER, MAP_INTVBI, MAP_USER2, MAP_DEINT, MAP_SEROUT} i2cms_map_t;

  // one byte event per cycle from the bit engine
  typedef struct packed {
    logic addr;
    logic sub;
    logic wr;
    logic rd;
    logic stop;
    logic [7:0] data;
  } i2cms_ev_t;

  // access handed to the selected map
  typedef struct packed {
    logic valid;
    logic write;
    i2cms_map_t map;
    logic [7:0] loc;
    logic [7:0] data;
  } i2cms_acc_t;

  typedef struct packed {
    logic hit;
    logic rd;
    i2cms_map_t map;
  } i2cms_dec_t;

endpackage

// File: hdl/i2cms_selector.sv
// Purpose: pick the register map or sub map that answers each serial-bus access
// Assumes: one byte event per cycle, already framed by the bit engine
// Notes: map contents live outside; only the three selector registers are held here
`timescale 1ns/100ps
module i2cms_selector
  import i2cms_pkg::*;
#(
  parameter logic [7:0] USER_TOP = LOC_TOP_DEFAULT,
  parameter logic [7:0] INTVBI_TOP = LOC_TOP_DEFAULT,
  parameter logic [7:0] USER2_TOP = LOC_TOP_DEFAULT,
  parameter logic [7:0] DEINT_TOP = LOC_TOP_DEFAULT,
  parameter logic [7:0] SEROUT_TOP = LOC_TOP_DEFAULT
)(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // strap
  input wire logic bus_id_select_pin,
  // byte events and answer
  input wire i2cms_ev_t ev,
  output logic ack,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // access to the maps
  output i2cms_acc_t acc,
  // selector state
  output logic [1:0] map_page_field,
  output logic [7:0] deint_map_id,
  output logic [7:0] serout_map_id
);

  // assertions below all sample on the core clock and stand down in reset, except reset_values_a, which stays on through reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_SUBADDR, S_XFER} i2cms_state_t;

  function automatic i2cms_map_t page_map(input logic [1:0] page);
    case (page)
      PAGE_USER: page_map = MAP_USER;
      PAGE_INTVBI: page_map = MAP_INTVBI;
      PAGE_USER2: page_map = MAP_USER2;
      default: page_map = MAP_NONE;
    endcase
  endfunction

  // the page field answers in every main-map sub map, otherwise there would be no way back
  function automatic logic main_sub(input i2cms_map_t m);
    main_sub = (m == MAP_USER || m == MAP_INTVBI || m == MAP_USER2);
  endfunction

  function automatic logic [7:0] top_of(input i2cms_map_t m);
    case (m)
      MAP_USER: top_of = USER_TOP;
      MAP_INTVBI: top_of = INTVBI_TOP;
      MAP_USER2: top_of = USER2_TOP;
      MAP_DEINT: top_of = DEINT_TOP;
      MAP_SEROUT: top_of = SEROUT_TOP;
      default: top_of = 8'h00;
    endcase
  endfunction

  // main id wins over a programmable id that collides with it
  function automatic i2cms_dec_t map_decode(input logic [7:0] b, input logic pin, input logic [1:0] page,
                                            input logic [7:0] d_id, input logic [7:0] s_id);
    map_decode = '{hit: 1'b0, rd: b[0], map: MAP_NONE};
    if (b[7:1] == {MAIN_ID_HIGH, pin})
    begin
      map_decode.map = page_map(page);
      map_decode.hit = (map_decode.map != MAP_NONE);
    end
    else if (d_id[7:1] != 7'h00 && b[7:1] == d_id[7:1])
    begin
      map_decode.map = MAP_DEINT;
      map_decode.hit = 1'b1;
    end
    else if (s_id[7:1] != 7'h00 && b[7:1] == s_id[7:1])
    begin
      map_decode.map = MAP_SEROUT;
      map_decode.hit = 1'b1;
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  i2cms_state_t state, next_state;
  i2cms_map_t cur_map, next_cur_map;
  logic dir_rd, next_dir_rd;
  logic [7:0] ptr, next_ptr;
  logic past_top, next_past_top;
  logic [7:0] page_reg, next_page_reg;
  logic [7:0] next_deint_map_id, next_serout_map_id;
  logic [7:0] next_rd_data;
  logic next_rd_valid;
  i2cms_acc_t next_acc;
  i2cms_dec_t dec;
  logic any_ev;

  assign map_page_field = page_reg[PAGE_LSB +: 2];
  assign any_ev = ev.addr | ev.sub | ev.wr | ev.rd | ev.stop;

  always_comb
  begin
    next_state = state;
    next_cur_map = cur_map;
    next_dir_rd = dir_rd;
    next_ptr = ptr;
    next_past_top = past_top;
    next_page_reg = page_reg;
    next_deint_map_id = deint_map_id;
    next_serout_map_id = serout_map_id;
    next_rd_data = rd_data;
    next_rd_valid = 1'b0;
    next_acc = acc;
    next_acc.valid = 1'b0;
    ack = 1'b0;
    dec = map_decode(ev.data, bus_id_select_pin, map_page_field, deint_map_id, serout_map_id);
    if (clk_en)
    begin
      if (ev.stop)
        next_state = S_IDLE;
      else if (ev.addr)
      begin
        ack = dec.hit;
        next_state = !dec.hit ? S_IDLE : (dec.rd ? S_XFER : S_SUBADDR);
        if (dec.hit)
        begin
          next_cur_map = dec.map;
          next_dir_rd = dec.rd;
        end
      end
      else
        case (state)
          S_SUBADDR:
            if (ev.sub && ev.data <= top_of(cur_map))
            begin
              ack = 1'b1;
              next_ptr = ev.data;
              next_past_top = 1'b0;
              next_state = S_XFER;
            end
            else if (any_ev)
              next_state = S_IDLE;
          S_XFER:
            if (ev.wr && !dir_rd && !past_top)
            begin
              ack = 1'b1;
              next_acc = '{valid: 1'b1, write: 1'b1, map: cur_map, loc: ptr, data: ev.data};
              if (main_sub(cur_map) && ptr == PAGE_LOC)
                next_page_reg = ev.data;
              if (cur_map == MAP_USER && ptr == DEINT_LOC)
                next_deint_map_id = ev.data;
              if (cur_map == MAP_USER && ptr == SEROUT_LOC)
                next_serout_map_id = ev.data;
              next_past_top = (ptr == top_of(cur_map));
              next_ptr = (ptr == top_of(cur_map)) ? ptr : ptr + 8'h01;
            end
            else if (ev.rd && dir_rd)
            begin
              ack = 1'b1;
              next_acc = '{valid: 1'b1, write: 1'b0, map: cur_map, loc: ptr, data: 8'h00};
              next_rd_valid = 1'b1;
              next_rd_data = 8'h00;
              if (main_sub(cur_map) && ptr == PAGE_LOC)
                next_rd_data = page_reg;
              if (cur_map == MAP_USER && ptr == DEINT_LOC)
                next_rd_data = deint_map_id;
              if (cur_map == MAP_USER && ptr == SEROUT_LOC)
                next_rd_data = serout_map_id;
              // reads past the top keep returning the top location
              next_ptr = (ptr == top_of(cur_map)) ? ptr : ptr + 8'h01;
            end
            else if (any_ev)
              next_state = S_IDLE;
          default:
            if (any_ev)
              next_state = S_IDLE;
        endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= S_IDLE;
      cur_map <= MAP_NONE;
      dir_rd <= 1'b0;
      ptr <= 8'h00;
      past_top <= 1'b0;
      page_reg <= PAGE_RST;
      deint_map_id <= MAP_ID_RST;
      serout_map_id <= MAP_ID_RST;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      acc <= '0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      cur_map <= next_cur_map;
      dir_rd <= next_dir_rd;
      ptr <= next_ptr;
      past_top <= next_past_top;
      page_reg <= next_page_reg;
      deint_map_id <= next_deint_map_id;
      serout_map_id <= next_serout_map_id;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      acc <= next_acc;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic live, main_hit, sub_wr;
  assign live = clk_en && !ev.stop;
  assign main_hit = live && ev.addr && ev.data[7:1] == {MAIN_ID_HIGH, bus_id_select_pin};
  assign sub_wr = live && !ev.addr && ev.wr && state == S_XFER && !dir_rd && !past_top && main_sub(cur_map);

  main_write_id_a: assert property (main_hit && !ev.data[0] && map_page_field != 2'h3 |-> ack ##1 state == S_SUBADDR)
    else $error("main map write id not taken");
  main_read_id_a: assert property (main_hit && ev.data[0] && map_page_field != 2'h3 |-> ack ##1 (state == S_XFER && dir_rd))
    else $error("main map read id not taken as read");
  page_user_a: assert property (main_hit && map_page_field == PAGE_USER |=> cur_map == MAP_USER)
    else $error("page 00 did not select user sub map");
  page_intvbi_a: assert property (main_hit && map_page_field == PAGE_INTVBI |=> cur_map == MAP_INTVBI)
    else $error("page 01 did not select interrupt sub map");
  page_user2_a: assert property (main_hit && map_page_field == PAGE_USER2 |=> cur_map == MAP_USER2)
    else $error("page 10 did not select second user sub map");
  // looked at one edge on: before the first edge in reset the registers may still be unknown
  reset_values_a: assert property (disable iff (1'b0) !arst_n |=> (page_reg == PAGE_RST
    && deint_map_id == MAP_ID_RST && serout_map_id == MAP_ID_RST))
    else $error("selector registers not cleared by reset");
  zero_id_a: assert property (live && ev.addr && ev.data[7:1] == 7'h00 |-> !ack)
    else $error("zero id was acknowledged");
  deint_hit_a: assert property (live && ev.addr && !main_hit && deint_map_id[7:1] != 7'h00
    && ev.data[7:1] == deint_map_id[7:1] |-> ack ##1 (cur_map == MAP_DEINT && dir_rd == $past(ev.data[0])))
    else $error("deinterlacer id not decoded");
  serout_hit_a: assert property (live && ev.addr && !main_hit && serout_map_id[7:1] != 7'h00
    && ev.data[7:1] == serout_map_id[7:1] && ev.data[7:1] != deint_map_id[7:1] |-> ack ##1 cur_map == MAP_SEROUT)
    else $error("serial-output id not decoded");
  page_store_a: assert property (sub_wr && ptr == PAGE_LOC |=> page_reg == $past(ev.data) ##1 1'b1)
    else $error("page field write lost");
  bad_loc_a: assert property (live && !ev.addr && state == S_SUBADDR && ev.sub && ev.data > top_of(cur_map)
    |-> !ack ##1 state == S_IDLE)
    else $error("location outside map was acknowledged");

  cover property (main_hit && ack ##1 cur_map == MAP_INTVBI);
  cover property (ack && ev.addr ##1 cur_map == MAP_DEINT);
  cover property (ack && ev.addr ##1 cur_map == MAP_SEROUT);
  cover property (state == S_XFER && past_top && ev.wr && clk_en);

endmodule // i2cms_selector

// File: dv/i2cms_master.sv
// Purpose: byte-level serial-bus master model for the map selector
// Assumes: events change by non-blocking assignment at a rising edge
// Notes: released data shows the inverse of the last byte
`timescale 1ns/100ps
module i2cms_master
  import i2cms_pkg::*;
(
  // clock
  input wire logic core_clk,
  // events and answer
  output i2cms_ev_t ev,
  input wire logic ack,
  input wire logic [7:0] rd_data
);
  initial ev = '0;

  // ----------------------------------------
  // one event, ack taken at the taking edge
  // ----------------------------------------
  task automatic put(input logic [4:0] kind, input logic [7:0] d, output logic a);
    ev <= {kind, d};
    @(posedge core_clk);
    a = ack;
  endtask

  task automatic wr_reg(input logic [7:0] id, loc, dat, output logic a);
    logic a0, a1, a2, x;
    put(5'h10, id, a0);
    put(5'h08, loc, a1);
    put(5'h04, dat, a2);
    put(5'h01, ~dat, x);
    ev <= {5'h00, dat};
    @(posedge core_clk);
    a = a0 & a1 & a2;
  endtask

  // pointer set by an empty write transfer, then one byte read
  task automatic rd_reg(input logic [7:0] id, loc, output logic a, output logic [7:0] d);
    logic a0, a1, a2, x;
    put(5'h10, {id[7:1], 1'b0}, a0);
    put(5'h08, loc, a1);
    put(5'h10, {id[7:1], 1'b1}, x);
    put(5'h02, ~loc, a2);
    put(5'h01, loc, x);
    d = rd_data;
    ev <= {5'h00, ~loc};
    @(posedge core_clk);
    a = a0 & a1 & a2;
  endtask
endmodule // i2cms_master

// File: dv/tb.sv
// Purpose: self-checking bench for the map selector
// Assumes: second user sub map tops out at 0x80
// Notes: page 11 locks the main id until reset, so it runs last
`timescale 1ns/100ps
module tb
  import i2cms_pkg::*;
;
  logic core_clk, arst_n, clk_en, pin, ack, rd_valid, a;
  logic [7:0] rd_data, deint_map_id, serout_map_id, d;
  logic [1:0] map_page_field;
  i2cms_ev_t ev;
  i2cms_acc_t acc;
  int errors = 0;
  int n_tests = 0;
  int n_acc = 0;
  int n_rd = 0;
  int acc_seen;
  int rd_seen;
  i2cms_map_t pmap[3] = '{MAP_USER, MAP_INTVBI, MAP_USER2};
  i2cms_map_t xmap[2] = '{MAP_DEINT, MAP_SEROUT};
  logic [7:0] xloc[2] = '{DEINT_LOC, SEROUT_LOC};
  logic [7:0] xid[2] = '{8'h84, 8'h88};

  i2cms_selector #(.USER2_TOP(8'h80)) dut (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
    .bus_id_select_pin(pin), .ev(ev), .ack(ack), .rd_data(rd_data), .rd_valid(rd_valid), .acc(acc),
    .map_page_field(map_page_field), .deint_map_id(deint_map_id), .serout_map_id(serout_map_id));
  i2cms_master m (.core_clk(core_clk), .ev(ev), .ack(ack), .rd_data(rd_data));

  // one-cycle strobes are gone by the time a task returns, so they are counted here
  always @(posedge core_clk)
  begin
    if (acc.valid)
      n_acc <= n_acc + 1;
    if (rd_valid)
      n_rd <= n_rd + 1;
  end

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_reset();
    chk({6'h00, map_page_field}, 8'h00);
    chk(deint_map_id, 8'h00);
    chk(serout_map_id, 8'h00);
  endtask

  initial
  begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    pin = 1'b0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    chk_reset();
    $display("test reset values done");
    for (int i = 0; i < 4; i++)
    begin
      pin <= i[1];
      m.wr_reg(i[0] ? 8'h42 : 8'h40, 8'h10, 8'h00, a);
      chk({7'h0, a}, {7'h0, i[1] == i[0]});
    end
    pin <= 1'b0;
    $display("test main id done");
    for (int p = 0; p < 3; p++)
    begin
      m.wr_reg(8'h40, PAGE_LOC, 8'(p << PAGE_LSB), a);
      chk({6'h00, map_page_field}, 8'(p));
      acc_seen = n_acc;
      m.wr_reg(8'h40, 8'h10, 8'h5A, a);
      chk({5'h00, acc.map}, {5'h00, pmap[p]});
      chk(acc.loc, 8'h10);
      chk(acc.data, 8'h5A);
      chk({7'h0, acc.write}, 8'h01);
      chk(8'(n_acc - acc_seen), 8'h01);
      m.wr_reg(8'h40, PAGE_LOC, 8'h00, a);
      chk({6'h00, map_page_field}, 8'h00);
    end
    $display("test page routing done");
    m.wr_reg(8'h40, PAGE_LOC, 8'h40, a);
    acc_seen = n_acc;
    m.wr_reg(8'h40, 8'h81, 8'h11, a);
    chk({7'h0, a}, 8'h00);
    chk(8'(n_acc - acc_seen), 8'h00);
    m.wr_reg(8'h40, 8'h80, 8'h11, a);
    chk({7'h0, a}, 8'h01);
    m.wr_reg(8'h40, PAGE_LOC, 8'h00, a);
    chk({6'h00, map_page_field}, 8'h00);
    $display("test missing location done");
    pin <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      m.wr_reg(8'h00, 8'h03, 8'h00, a);
      chk({7'h0, a}, 8'h00);
      m.wr_reg(xid[k], 8'h03, 8'h00, a);
      chk({7'h0, a}, 8'h00);
      m.wr_reg(8'h42, xloc[k], xid[k], a);
      chk(k ? serout_map_id : deint_map_id, xid[k]);
      m.wr_reg(8'h42, PAGE_LOC, 8'h20, a);
      m.wr_reg(xid[k], 8'h03, 8'hA5, a);
      chk({7'h0, a}, 8'h01);
      chk({5'h00, acc.map}, {5'h00, xmap[k]});
      m.rd_reg(xid[k] | 8'h01, 8'h03, a, d);
      chk({7'h0, a}, 8'h01);
      m.wr_reg(8'h42, PAGE_LOC, 8'h00, a);
      rd_seen = n_rd;
      m.rd_reg(8'h43, xloc[k], a, d);
      chk(d, xid[k]);
      chk(8'(n_rd - rd_seen), 8'h01);
      chk({7'h0, acc.write}, 8'h00);
    end
    pin <= 1'b0;
    $display("test programmable maps done");
    clk_en <= 1'b0;
    m.wr_reg(8'h40, 8'h10, 8'h00, a);
    chk({7'h0, a}, 8'h00);
    clk_en <= 1'b1;
    m.wr_reg(8'h40, PAGE_LOC, 8'h60, a);
    m.wr_reg(8'h40, 8'h10, 8'h00, a);
    chk({7'h0, a}, 8'h00);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    chk_reset();
    m.wr_reg(8'h40, 8'h10, 8'h00, a);
    chk({7'h0, a}, 8'h01);
    m.wr_reg(8'h84, 8'h10, 8'h00, a);
    chk({7'h0, a}, 8'h00);
    $display("test mid-run reset done");
    close_out();
  end

  // the sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge core_clk);
    errors++;
    close_out();
  end
endmodule // tb
